// ### core/fsic_ctrl.sv
// streaming controller around a multichannel filter datapath
// Behaviour
// - pipeline depth one to three register levels
// - withhold sink ready when unable to accept
// - coefficient ports stay outside the handshake
// - error codes 00,01,10,11 as defined
// - links carry only ready valid data channel error start end
// - valid low means data is don't-care
// - beat transfers only when ready and valid
// - packets framed by start and end flags
// - no channel input; position gives channel
// - output drives channel index with each result
// - error lines stay 00 when error-free
// - on error reset controller, hunt next start
// - pass upstream error code to output
// - error leaves datapath state untouched
// - reset synchronous active low, hold several cycles
// - stall processing when no input is valid; beats already in the delay line still drain to the output
module fsic_ctrl
   import fsic_pkg::*;
#(
   parameter int DATA_W   = 16,             // sample and result width
   parameter int N_CHAN   = 4,              // channels per packet
   parameter int PIPE_LVL = FSIC_PIPE_DEF,  // extra register levels
   parameter int CHAN_W   = (N_CHAN > 1) ? $clog2(N_CHAN) : 1
)
(
   input  wire logic              i_core_clk,
   input  wire logic              i_rst_n,
   // sink side, from upstream; only the listed signal types
   output logic                   o_sink_ready,
   input  wire logic              i_sink_valid,
   input  wire logic [DATA_W-1:0] i_sink_data,
   input  wire logic              i_sink_sop,
   input  wire logic              i_sink_eop,
   input  wire logic [1:0]        i_sink_error,
   // source side, to downstream
   input  wire logic              i_source_ready,
   output logic                   o_source_valid,
   output logic      [DATA_W-1:0] o_source_data,
   output logic      [CHAN_W-1:0] o_source_channel,
   output logic                   o_source_sop,
   output logic                   o_source_eop,
   output logic      [1:0]        o_source_error
   // no coefficient ports: reload stays outside this handshake
);
   ////////////////////////////////////////////////////////////////////////////
   // constants
   localparam int                PW        = DATA_W + CHAN_W + 2;  // pipe payload
   localparam logic [CHAN_W-1:0] CHAN_LAST = CHAN_W'(N_CHAN - 1);
   localparam logic [CHAN_W-1:0] CHAN_ZERO = '0;

   // out-of-range depths are clamped to the nearest legal level; a line
   // with no stage cannot be built, and more than the maximum buys nothing
   localparam int PE = (PIPE_LVL < FSIC_PIPE_MIN) ? FSIC_PIPE_MIN :
                       (PIPE_LVL > FSIC_PIPE_MAX) ? FSIC_PIPE_MAX : PIPE_LVL;
   localparam int               OCC_W    = $clog2(FSIC_PIPE_MAX + 1);  // beat count width
   localparam logic [OCC_W-1:0] OCC_FULL = OCC_W'(PE);                 // every stage full

   ////////////////////////////////////////////////////////////////////////////
   // state
   fsic_state_t       state_ff;       // hunting or running
   fsic_state_t       nxt_state;
   logic [CHAN_W-1:0] chan_ff;        // channel of next expected input beat
   logic [CHAN_W-1:0] nxt_chan;
   logic              out_vld_ff;     // output skid register valid
   logic [DATA_W-1:0] out_data_ff;
   logic [CHAN_W-1:0] out_chan_ff;
   logic              out_sop_ff;
   logic              out_eop_ff;
   logic [1:0]        out_err_ff;
   logic              sink_rdy_ff;    // registered sink ready
   logic [1:0]        err_ff;         // error awaiting output
   logic [1:0]        nxt_err;
   logic [OCC_W-1:0]  occ_ff;         // beats held in the delay line
   logic [OCC_W-1:0]  nxt_occ;

   ////////////////////////////////////////////////////////////////////////////
   // sink side decode
   wire logic take      = sink_rdy_ff & i_sink_valid;
   wire logic up_err    = take & (i_sink_error != FSIC_ERR_NONE);
   wire logic at_first  = (chan_ff == CHAN_ZERO);
   wire logic at_last   = (chan_ff == CHAN_LAST);
   // framing checks only while running; hunting accepts only a start
   wire logic no_sop    = take & (state_ff == FSIC_RUN) & at_first & ~i_sink_sop;
   wire logic no_eop    = take & (state_ff == FSIC_RUN) & at_last & ~i_sink_eop;
   wire logic early_eop = take & (state_ff == FSIC_RUN) & ~at_last & i_sink_eop
                        | take & (state_ff == FSIC_RUN) & ~at_first & i_sink_sop;
   wire logic det_err   = no_sop | no_eop | early_eop;
   // a start while hunting opens a packet; a single-channel packet carries both flags
   wire logic hunt_sop  = take & (state_ff == FSIC_HUNT) & i_sink_sop
                        & ~up_err & (~i_sink_eop | (N_CHAN == 1));
   wire logic good_beat = take & ~up_err & ~det_err
                        & ((state_ff == FSIC_RUN) | hunt_sop);
   // detected code, upstream code takes priority since it is passed on
   wire logic [1:0] det_code = up_err    ? i_sink_error   :
                               no_sop    ? FSIC_ERR_NO_SOP :
                               no_eop    ? FSIC_ERR_NO_EOP : FSIC_ERR_BAD_EOP;

   ////////////////////////////////////////////////////////////////////////////
   // output and pipe flow
   wire logic pipe_vld;
   wire logic [PW-1:0] pipe_pay;
   // the line moves when its tail can leave or is empty
   wire logic out_free  = ~out_vld_ff | i_source_ready;
   wire logic adv       = out_free | ~pipe_vld;
   wire logic tail_go   = pipe_vld & out_free;   // tail beat moves to the output
   // one beat in per good beat, one out per tail move
   assign nxt_occ = occ_ff + OCC_W'(good_beat) - OCC_W'(tail_go);
   // ready is a register, so it only promises a stage that stays free whatever
   // downstream does next; the price is a bubble each time the line fills
   wire logic nxt_rdy   = (nxt_occ < OCC_FULL);
   wire logic out_load  = out_free & (pipe_vld | (err_ff != FSIC_ERR_NONE));
   wire logic [PW-1:0] in_pay = {i_sink_data, chan_ff, i_sink_sop, i_sink_eop};

   // register levels of latency; datapath untouched by errors
   fsic_pipe #(
      .W     (PW),
      .DEPTH (PE)
   ) u_pipe (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_adv      (adv),
      .i_vld      (good_beat),
      .i_data     (in_pay),
      .o_vld      (pipe_vld),
      .o_data     (pipe_pay)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state: errors send the controller back to hunting
   always_comb
   begin
      nxt_state = state_ff;
      nxt_chan  = chan_ff;
      nxt_err   = err_ff;
      if (take && (up_err || det_err))
      begin
         nxt_state = FSIC_HUNT;
         nxt_chan  = CHAN_ZERO;
         nxt_err   = det_code;
      end
      else if (good_beat)
      begin
         // wrap after the last channel; stay running so that the next
         // packet's channel-0 beat is still checked for its start flag
         nxt_state = FSIC_RUN;
         nxt_chan  = at_last ? CHAN_ZERO : chan_ff + CHAN_W'(1);
         // a pending code leaves with any output load, result or not
         if (out_load)
            nxt_err = FSIC_ERR_NONE;
      end
      else if (out_load)
         nxt_err = FSIC_ERR_NONE;
      case (nxt_state)
         FSIC_HUNT : nxt_state = nxt_state;
         FSIC_RUN  : nxt_state = nxt_state;
         default   : nxt_state = FSIC_HUNT;
      endcase
   end

   // control registers
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         state_ff    <= FSIC_HUNT;
         chan_ff     <= CHAN_ZERO;
         err_ff      <= FSIC_ERR_NONE;
         sink_rdy_ff <= 1'b0;
         occ_ff      <= '0;
      end
      else
      begin
         state_ff    <= nxt_state;
         chan_ff     <= nxt_chan;
         err_ff      <= nxt_err;
         sink_rdy_ff <= nxt_rdy;
         occ_ff      <= nxt_occ;
      end
   end

   // output beat register; error is reported on its own beat or with a result
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         out_vld_ff <= 1'b0;
         out_err_ff <= FSIC_ERR_NONE;
      end
      else if (out_load)
      begin
         out_vld_ff <= 1'b1;
         out_err_ff <= err_ff;
      end
      else if (i_source_ready)
      begin
         out_vld_ff <= 1'b0;
         out_err_ff <= FSIC_ERR_NONE;
      end
   end

   // payload fields, held while downstream stalls
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         out_data_ff <= '0;
         out_chan_ff <= CHAN_ZERO;
         out_sop_ff  <= 1'b0;
         out_eop_ff  <= 1'b0;
      end
      else if (out_load)
      begin
         {out_data_ff, out_chan_ff, out_sop_ff, out_eop_ff} <= pipe_pay;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ports straight from flip-flops
   assign o_sink_ready     = sink_rdy_ff;
   assign o_source_valid   = out_vld_ff;
   assign o_source_data    = out_data_ff;
   assign o_source_channel = out_chan_ff;
   assign o_source_sop     = out_sop_ff;
   assign o_source_eop     = out_eop_ff;
   assign o_source_error   = out_err_ff;
endmodule // fsic_ctrl

// ### core/fsic_pipe.sv
// delay line of result beats with per-stage hold under back-pressure
module fsic_pipe
   import fsic_pkg::*;
#(
   parameter int W     = 8,   // payload width
   parameter int DEPTH = 1    // register levels
)
(
   input  wire logic         i_core_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_adv,       // tail stage may move on
   input  wire logic         i_vld,       // beat entering stage 0
   input  wire logic [W-1:0] i_data,      // payload entering stage 0
   output logic              o_vld,       // last stage valid
   output logic      [W-1:0] o_data       // last stage payload
);
   ////////////////////////////////////////////////////////////////////////////
   logic         vld_ff  [DEPTH];  // stage valid bits
   logic [W-1:0] data_ff [DEPTH];  // stage payloads
   wire  logic [DEPTH:0] load;     // stage may take the beat behind it

   // the tail leaves only when told; a bubble anywhere lets the stages behind it close up,
   // so stage 0 can always take a beat while the line is not completely full
   assign load[DEPTH] = i_adv;

   // one register level per stage
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++)
      begin : g_stage
         wire logic         in_vld  = (g == 0) ? i_vld  : vld_ff[(g == 0) ? 0 : g-1];
         wire logic [W-1:0] in_data = (g == 0) ? i_data : data_ff[(g == 0) ? 0 : g-1];
         // an empty stage always loads; a full one only when it moves on
         assign load[g] = ~vld_ff[g] | load[g+1];
         always_ff @(posedge i_core_clk)
         begin
            if (!i_rst_n)
               vld_ff[g] <= 1'b0;
            else if (load[g])
               vld_ff[g] <= in_vld;
         end
         // payload is not reset; only valid matters
         always_ff @(posedge i_core_clk)
         begin
            if (load[g])
               data_ff[g] <= in_data;
         end
      end
   endgenerate

   assign o_vld  = vld_ff[DEPTH-1];
   assign o_data = data_ff[DEPTH-1];
endmodule // fsic_pipe

// ### core/fsic_pkg.sv
// shared constants and types for the fir stream interface controller
package fsic_pkg;
   // error codes carried on the two-bit error lines
   localparam logic [1:0] FSIC_ERR_NONE    = 2'h0;  // no error
   localparam logic [1:0] FSIC_ERR_NO_SOP  = 2'h1;  // missing start of packet
   localparam logic [1:0] FSIC_ERR_NO_EOP  = 2'h2;  // missing end of packet
   localparam logic [1:0] FSIC_ERR_BAD_EOP = 2'h3;  // unexpected end or other
   // pipeline depth limits
   localparam int FSIC_PIPE_MIN = 1;
   localparam int FSIC_PIPE_MAX = 3;
   localparam int FSIC_PIPE_DEF = 1;
   // controller states
   typedef enum logic [0:0] {
      FSIC_HUNT,   // waiting for a start of packet
      FSIC_RUN     // inside packet traffic
   } fsic_state_t;
endpackage : fsic_pkg

// ### dv/fsic_ctrl_props.sv
// port-level checks for the stream interface controller
module fsic_ctrl_props
   import fsic_pkg::*;
#(
   parameter int DATA_W   = 16,
   parameter int N_CHAN   = 4,
   parameter int PIPE_LVL = 1,
   parameter int CHAN_W   = 2
)
(
   input wire logic              i_core_clk,
   input wire logic              i_rst_n,
   input wire logic              o_sink_ready,
   input wire logic              i_sink_valid,
   input wire logic [DATA_W-1:0] i_sink_data,
   input wire logic              i_sink_sop,
   input wire logic              i_sink_eop,
   input wire logic [1:0]        i_sink_error,
   input wire logic              i_source_ready,
   input wire logic              o_source_valid,
   input wire logic [DATA_W-1:0] o_source_data,
   input wire logic [CHAN_W-1:0] o_source_channel,
   input wire logic              o_source_sop,
   input wire logic              o_source_eop,
   input wire logic [1:0]        o_source_error
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////////////////////
   logic [3:0] absorb_ff;   // beats swallowed while the output is stalled
   always_ff @(posedge i_core_clk)
      if (!i_rst_n || !(o_source_valid && !i_source_ready))
         absorb_ff <= 4'h0;
      else if (o_sink_ready && i_sink_valid && absorb_ff != 4'hF)
         absorb_ff <= absorb_ff + 4'h1;
   sequence s_take;
      o_sink_ready && i_sink_valid && i_sink_sop && i_sink_error == FSIC_ERR_NONE;
   endsequence
   sequence s_stall;
      o_source_valid && !i_source_ready;
   endsequence
   property p_hold;
      s_stall |=> o_source_valid && $stable(o_source_data) && $stable(o_source_error);
   endproperty
   property p_drop;
      $fell(o_source_valid) |-> $past(i_source_ready);
   endproperty
   property p_sop_ch;
      o_source_valid && o_source_sop && o_source_error == FSIC_ERR_NONE
         |-> o_source_channel == '0;
   endproperty
   property p_eop_ch;
      o_source_valid && o_source_eop && o_source_error == FSIC_ERR_NONE
         |-> o_source_channel == CHAN_W'(N_CHAN - 1);
   endproperty
   property p_rst;
      disable iff (1'b0) !i_rst_n |=> !o_source_valid && !o_sink_ready;
   endproperty
   property p_rdy;
      $rose(i_rst_n) |=> o_sink_ready;
   endproperty
   property p_lat;
      s_take |-> ##[1:40] o_source_valid;
   endproperty
   property p_absorb;
      absorb_ff <= 4'(PIPE_LVL + 2);
   endproperty
   a_hold: assert property (p_hold)
      else $error("source beat changed while stalled");
   a_drop: assert property (p_drop)
      else $error("source valid dropped without a transfer");
   a_sop_ch: assert property (p_sop_ch)
      else $error("start flag on a nonzero channel");
   a_eop_ch: assert property (p_eop_ch)
      else $error("end flag not on the last channel");
   a_rst: assert property (p_rst)
      else $error("outputs active during reset");
   a_rdy: assert property (p_rdy)
      else $error("sink ready late after reset");
   a_lat: assert property (p_lat)
      else $error("taken start beat never produced a result");
   a_absorb: assert property (p_absorb)
      else $error("sink kept taking beats under a stall");
endmodule // fsic_ctrl_props
bind fsic_ctrl fsic_ctrl_props #(.DATA_W(DATA_W), .N_CHAN(N_CHAN), .PIPE_LVL(PIPE_LVL),
   .CHAN_W(CHAN_W)) u_props (.*);

// ### dv/fsic_ctrl_tb_top.sv
// self-checking bench for the stream interface controller
module fsic_ctrl_tb_top;
   import fsic_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DW = 16;
   localparam int NC = 4;
   localparam int BW = DW + 6;
   logic i_core_clk = 0, i_rst_n = 0, i_sink_valid = 0, i_sink_sop = 0, i_sink_eop = 0;
   logic [DW-1:0] i_sink_data = '0;
   logic [1:0] i_sink_error = '0, sink_mode = '0;
   wire logic o_sink_ready, i_source_ready, o_source_valid, o_source_sop, o_source_eop;
   wire logic [DW-1:0] o_source_data;
   wire logic [1:0] o_source_channel, o_source_error;
   int num_errors = 0, total_checks = 0, cyc = 0;
   fsic_ctrl #(.DATA_W(DW), .N_CHAN(NC), .PIPE_LVL(2)) uut (.*);
   fsic_sink_model #(.DATA_W(DW), .CHAN_W(2)) m (.i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n), .i_mode(sink_mode), .o_ready(i_source_ready),
      .i_valid(o_source_valid), .i_data(o_source_data), .i_chan(o_source_channel),
      .i_sop(o_source_sop), .i_eop(o_source_eop), .i_err(o_source_error));
   always #50 i_core_clk = ~i_core_clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(string nm, logic [BW-1:0] e, logic [BW-1:0] g);
      total_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // beat held unchanged until an edge where ready was high
   task automatic send(logic [DW-1:0] d, logic s, logic e, logic [1:0] er);
      logic t;
      {i_sink_valid, i_sink_data, i_sink_sop, i_sink_eop, i_sink_error} = {1'b1, d, s, e, er};
      for (int k = 0; k < 200; k++)
      begin
         t = o_sink_ready;
         @(posedge i_core_clk);
         #1;
         if (t)
            break;
      end
      chk("beat taken", 1, t);
   endtask
   task automatic pkt(logic [DW-1:0] b);
      for (int k = 0; k < NC; k++)
         send(b + DW'(k), k == 0, k == NC - 1, 2'h0);
   endtask
   task automatic drain();
      int q;
      q = 0;
      i_sink_valid = 0;
      for (int k = 0; k < 400 && q < 12; k++)
      begin
         @(posedge i_core_clk);
         #1;
         q = o_source_valid ? 0 : q + 1;
      end
      chk("output idle", 1, q >= 12);
   endtask
   task automatic expect_pkt(logic [DW-1:0] b);
      for (int k = 0; k < NC; k++)
         chk("beat", {2'h0, k == NC - 1, k == 0, 2'(k), b + DW'(k)}, m.q.pop_front());
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic sc_basic();
      pkt(16'h1000);
      pkt(16'h2000);
      drain();
      expect_pkt(16'h1000);
      expect_pkt(16'h2000);
   endtask
   task automatic sc_stall();
      sink_mode = 2'h2;
      fork
         pkt(16'h3000);
         begin
            repeat (20) @(posedge i_core_clk);
            #1;
            chk("sink ready", 0, o_sink_ready);
            sink_mode = 2'h1;
         end
      join
      drain();
      expect_pkt(16'h3000);
      sink_mode = 2'h0;
   endtask
   task automatic sc_err();
      int nb[4] = '{1, 4, 2, 1};
      logic [3:0] sm[4] = '{4'h0, 4'h1, 4'h1, 4'h1};
      logic [3:0] em[4] = '{4'h0, 4'h0, 4'h2, 4'h0};
      logic [1:0] ue[4] = '{2'h0, 2'h0, 2'h0, 2'h2};
      logic [1:0] ex[4] = '{FSIC_ERR_NO_SOP, FSIC_ERR_NO_EOP, FSIC_ERR_BAD_EOP, 2'h2};
      logic [1:0] seen;
      for (int c = 0; c < 4; c++)
      begin
         pkt(16'h4000);
         for (int b = 0; b < nb[c]; b++)
            send(16'h5000 + DW'(b), sm[c][b], em[c][b], b == nb[c] - 1 ? ue[c] : 2'h0);
         drain();
         seen = 2'h0;
         foreach (m.q[i])
            if (seen == 2'h0)
               seen = m.q[i][BW-1:BW-2];
         chk("error code", ex[c], seen);
         m.q.delete();
         send(16'h6000, 1'b0, 1'b0, 2'h0);
         pkt(16'h7000);
         drain();
         expect_pkt(16'h7000);
      end
   endtask
   task automatic sc_rst();
      pkt(16'h8000);
      {i_rst_n, i_sink_valid} = 2'b00;
      repeat (3) @(posedge i_core_clk);
      #1;
      chk("valid in reset", 0, {o_source_valid, o_sink_ready});
      i_rst_n = 1;
      repeat (2) @(posedge i_core_clk);
      #1;
      chk("ready after reset", 1, o_sink_ready);
      m.q.delete();
      pkt(16'h9000);
      drain();
      expect_pkt(16'h9000);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge i_core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         summarize();
      end
   end
   initial
   begin
      repeat (6) @(posedge i_core_clk);
      #1;
      i_rst_n = 1;
      sc_basic();
      sc_stall();
      sc_err();
      sc_rst();
      summarize();
   end
endmodule // fsic_ctrl_tb_top

// ### dv/fsic_sink_model.sv
// downstream sink model: stalls on demand and records every taken beat
module fsic_sink_model
#(
   parameter int DATA_W = 16,
   parameter int CHAN_W = 2
)
(
   input  wire logic              i_core_clk,
   input  wire logic              i_rst_n,
   input  wire logic [1:0]        i_mode,    // 0 always, 1 one in four, 2 never
   output logic                   o_ready,
   input  wire logic              i_valid,
   input  wire logic [DATA_W-1:0] i_data,
   input  wire logic [CHAN_W-1:0] i_chan,
   input  wire logic              i_sop,
   input  wire logic              i_eop,
   input  wire logic [1:0]        i_err
);
   logic [DATA_W+CHAN_W+3:0] q[$];          // {err, eop, sop, chan, data}
   logic [1:0]               ph_ff = 2'h0;  // slow-mode phase
   initial o_ready = 1'b0;
   always @(posedge i_core_clk)
   begin
      ph_ff <= ph_ff + 2'h1;
      o_ready <= i_rst_n && (i_mode == 2'h0 || (i_mode == 2'h1 && ph_ff == 2'h0));
      if (i_rst_n && i_valid && o_ready)
         q.push_back({i_err, i_eop, i_sop, i_chan, i_data});
   end
endmodule // fsic_sink_model
